// ---- include/pba_map.vh ----
// constants for the front-panel button/address block: register offsets,
// field positions, reset values and timing figures.
// assumes a 20 MHz system clock; counts are derived in the modules.
`ifndef PBA_MAP_VH
`define PBA_MAP_VH

// ***************************************************************
// register offsets (byte addresses, one word each)
// ***************************************************************
`define PBA_REG_ADDR      8'h00
`define PBA_REG_STATUS    8'h04

// ***************************************************************
// status field positions
// ***************************************************************
`define PBA_ST_STATE_LSB  0
`define PBA_ST_LEDS_LSB   8
`define PBA_ST_EDIT_LSB   16

// ***************************************************************
// reset values and the largest decimal digit
// ***************************************************************
`define PBA_ADDR_RST      8'h02
`define PBA_NINE          4'h9

// ***************************************************************
// timing figures
// ***************************************************************
`define PBA_CLK_HZ        20000000
`define PBA_HOLD_CFG_MS   5000
`define PBA_HOLD_STEP_MS  2500
`define PBA_IDLE_MS       10000
`define PBA_DEB_MS        20
`define PBA_GAP_MS        400
`define PBA_BLINK_MS      250
`define PBA_ACT_MS        100
`define PBA_CYC_PER_MS    (`PBA_CLK_HZ / 1000)

`endif

// ---- rtl/pba_debounce.v ----
// two-flop synchroniser plus stability filter for one panel input.
// assumes the input is asynchronous to clk_sys_i and bounces briefly.
`timescale 1ns/10ps
`default_nettype none

module pba_debounce #(
   parameter integer CW      = 20,
   parameter integer DEB_CYC = 400000,
   parameter         RST_LVL = 1'b1
) (
   input  wire clk_sys_i,
   input  wire rst_i,
   input  wire pin_i,
   output wire level_o
);

   localparam [CW-1:0] DEB_LAST = DEB_CYC[CW-1:0] - 1'b1;

   reg          sync1_q;
   reg          sync2_q;
   reg          level_q;
   reg [CW-1:0] cnt_q;

   // first flop is read by the second only
   always @(posedge clk_sys_i)
   begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
   end

   // accept a new level only once it has held for the whole window
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         level_q <= RST_LVL;
         cnt_q   <= {CW{1'b0}};
      end
      else if (sync2_q == level_q)
         cnt_q <= {CW{1'b0}};
      else if (cnt_q == DEB_LAST)
      begin
         level_q <= sync2_q;
         cnt_q   <= {CW{1'b0}};
      end
      else
         cnt_q <= cnt_q + 1'b1;
   end

   assign level_o = level_q;

endmodule // pba_debounce

`default_nettype wire

// ---- rtl/pba_act_led.v ----
// activity indicator: stretches short activity pulses and blinks the led.
// assumes act_i is a one-cycle pulse on clk_sys_i, blink_i a slow square.
`timescale 1ns/10ps
`default_nettype none

module pba_act_led #(
   parameter integer CW       = 22,
   parameter integer HOLD_CYC = 2000000
) (
   input  wire clk_sys_i,
   input  wire rst_i,
   input  wire act_i,
   input  wire blink_i,
   output wire led_o
);

   localparam [CW-1:0] HOLD_W = HOLD_CYC[CW-1:0];

   reg [CW-1:0] cnt_q;
   reg          led_q;

   // retrigger on each pulse so a busy link blinks without gaps
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cnt_q <= {CW{1'b0}};
         led_q <= 1'b0;
      end
      else
      begin
         if (act_i)
            cnt_q <= HOLD_W;
         else if (cnt_q != {CW{1'b0}})
            cnt_q <= cnt_q - 1'b1;
         led_q <= (cnt_q != {CW{1'b0}}) & blink_i; // off when idle
      end
   end

   assign led_o = led_q;

endmodule // pba_act_led

`default_nettype wire

// ---- rtl/pba_panel.v ----
// front-panel logic: one button, a two-digit address display, four
// status leds and an ahb-lite register slave for the slave address.
// assumes one 20 MHz clock, synchronous reset, one ahb-lite master and
// activity/fault/usb inputs from logic on the same clock.
//
// Overview of operation
// - after reset show address, both digits steady
// - 5 s hold in normal starts blinking
// - click while blinking enters configuration mode
// - configuration mode lets serial ports transfer config
// - 2.5 s hold in configuration returns normal
// - usb transfer done returns to normal mode
// - double click edits, high digit blinks
// - each click increments the selected digit
// - 2.5 s hold moves editing to low digit
// - 2.5 s hold on low digit saves address
// - over 10 s idle discards edit
// - fieldbus activity led blinks during exchange
// - fieldbus fault led steady on failure
// - serial receive led blinks while receiving
// - serial transmit led blinks while sending
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pba_map.vh"

module pba_panel #(
   parameter integer CW        = 28,
   parameter integer HOLD_CFG  = `PBA_HOLD_CFG_MS * `PBA_CYC_PER_MS,
   parameter integer HOLD_STEP = `PBA_HOLD_STEP_MS * `PBA_CYC_PER_MS,
   parameter integer IDLE_CYC  = `PBA_IDLE_MS * `PBA_CYC_PER_MS,
   parameter integer DEB_CYC   = `PBA_DEB_MS * `PBA_CYC_PER_MS,
   parameter integer GAP_CYC   = `PBA_GAP_MS * `PBA_CYC_PER_MS,
   parameter integer BLINK_CYC = `PBA_BLINK_MS * `PBA_CYC_PER_MS,
   parameter integer ACT_CYC   = `PBA_ACT_MS * `PBA_CYC_PER_MS
) (
   input  wire        clk_sys_i,
   input  wire        rst_i,
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire [31:0] hrdata_o,
   output wire        hreadyout_o,
   output wire        hresp_o,
   input  wire        button_n_i,
   input  wire        fb_active_i,
   input  wire        fb_fault_i,
   input  wire        rx_active_i,
   input  wire        tx_active_i,
   input  wire        usb_cfg_done_i,
   output wire [3:0]  digit_hi_o,
   output wire [3:0]  digit_lo_o,
   output wire        digit_hi_en_o,
   output wire        digit_lo_en_o,
   output wire [7:0]  slave_addr_o,
   output wire        cfg_mode_o,
   output wire        fieldbus_activity_led_o,
   output wire        fieldbus_fault_led_o,
   output wire        rx_led_o,
   output wire        tx_led_o
);

   // ***************************************************************
   // constants and state codes
   // ***************************************************************
   localparam [CW-1:0] HOLD_CFG_W  = HOLD_CFG[CW-1:0];
   localparam [CW-1:0] HOLD_STEP_W = HOLD_STEP[CW-1:0];
   localparam [CW-1:0] IDLE_W      = IDLE_CYC[CW-1:0];
   localparam [CW-1:0] GAP_W       = GAP_CYC[CW-1:0];
   localparam [CW-1:0] BLINK_W     = BLINK_CYC[CW-1:0];
   localparam [7:0]    ADDR_RST    = `PBA_ADDR_RST;

   localparam [4:0] ST_NORM  = 5'b00001;
   localparam [4:0] ST_ARMED = 5'b00010;
   localparam [4:0] ST_CFG   = 5'b00100;
   localparam [4:0] ST_EDHI  = 5'b01000;
   localparam [4:0] ST_EDLO  = 5'b10000;

   // decimal increment, nine wraps back to zero
   function [3:0] inc_dec;
      input [3:0] d;
      begin
         if (d >= `PBA_NINE)
            inc_dec = 4'h0;
         else
            inc_dec = d + 4'h1;
      end
   endfunction

   // both nibbles must be decimal digits
   function bcd_ok;
      input [7:0] v;
      begin
         bcd_ok = (v[7:4] <= `PBA_NINE) && (v[3:0] <= `PBA_NINE);
      end
   endfunction

   // ***************************************************************
   // declarations
   // ***************************************************************
   wire          btn_lvl_n;
   wire          btn_dn;
   wire          rel_edge;
   wire          short_rel;
   wire          hold_step;
   wire          hold_cfg;
   wire          idle_to;
   wire          ahb_go;
   wire [2:0]    act_in;
   wire [2:0]    act_led;
   reg           btn_prev_q;
   reg  [CW-1:0] hold_cnt_q;
   reg  [CW-1:0] gap_cnt_q;
   reg           pend_q;
   reg           single_q;
   reg           double_q;
   reg  [CW-1:0] idle_cnt_q;
   reg  [CW-1:0] blink_cnt_q;
   reg           blink_q;
   reg  [4:0]    state_q;
   reg  [7:0]    addr_q;
   reg  [7:0]    edit_q;
   reg           wr_pend_q;
   reg  [7:0]    wr_addr_q;
   reg  [31:0]   hrdata_q;
   reg  [31:0]   rd_val;
   reg  [3:0]    dig_hi_q;
   reg  [3:0]    dig_lo_q;
   reg           dig_hi_en_q;
   reg           dig_lo_en_q;
   reg           fault_led_q;

   // ***************************************************************
   // button conditioning and classification
   // ***************************************************************
   pba_debounce #(
      .CW      (CW),
      .DEB_CYC (DEB_CYC),
      .RST_LVL (1'b1)
   ) u_deb (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .pin_i     (button_n_i),
      .level_o   (btn_lvl_n)
   );

   assign btn_dn    = ~btn_lvl_n;
   assign rel_edge  = btn_prev_q & ~btn_dn;
   // a press shorter than the step hold counts as a click
   assign short_rel = rel_edge & (hold_cnt_q < HOLD_STEP_W);
   // hold events fire once, while the button is still down
   assign hold_step = btn_dn & (hold_cnt_q == HOLD_STEP_W - 1'b1);
   assign hold_cfg  = btn_dn & (hold_cnt_q == HOLD_CFG_W - 1'b1);

   // press length counter, saturates so a very long hold stays long
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         btn_prev_q <= 1'b0;
         hold_cnt_q <= {CW{1'b0}};
      end
      else
      begin
         btn_prev_q <= btn_dn;
         if (~btn_dn)
            hold_cnt_q <= {CW{1'b0}};
         else if (hold_cnt_q != HOLD_CFG_W)
            hold_cnt_q <= hold_cnt_q + 1'b1;
      end
   end

   // a click waits out the gap; a second click inside it is a double.
   // the wait delays single clicks by the gap, traded for one button.
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pend_q    <= 1'b0;
         gap_cnt_q <= {CW{1'b0}};
         single_q  <= 1'b0;
         double_q  <= 1'b0;
      end
      else
      begin
         single_q <= 1'b0;
         double_q <= 1'b0;
         if (short_rel)
         begin
            pend_q    <= ~pend_q;
            double_q  <= pend_q;
            gap_cnt_q <= {CW{1'b0}};
         end
         else if (pend_q)
         begin
            if (gap_cnt_q == GAP_W - 1'b1)
            begin
               pend_q   <= 1'b0;
               single_q <= 1'b1;
            end
            else
               gap_cnt_q <= gap_cnt_q + 1'b1;
         end
      end
   end

   // ***************************************************************
   // inactivity timer and blink phase
   // ***************************************************************
   assign idle_to = (idle_cnt_q == IDLE_W);

   // any press restarts the timer; it only runs while editing or armed
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
         idle_cnt_q <= {CW{1'b0}};
      else if (btn_dn | rel_edge | ~(state_q[1] | state_q[3] | state_q[4]))
         idle_cnt_q <= {CW{1'b0}};
      else if (~idle_to)
         idle_cnt_q <= idle_cnt_q + 1'b1;
   end

   // one shared phase keeps display and leds blinking in step
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         blink_cnt_q <= {CW{1'b0}};
         blink_q     <= 1'b1;
      end
      else if (blink_cnt_q == BLINK_W - 1'b1)
      begin
         blink_cnt_q <= {CW{1'b0}};
         blink_q     <= ~blink_q;
      end
      else
         blink_cnt_q <= blink_cnt_q + 1'b1;
   end

   // ***************************************************************
   // panel mode machine and address store
   // ***************************************************************
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_NORM;
         edit_q  <= `PBA_ADDR_RST;
      end
      else
      begin
         case (state_q)
            ST_NORM:
               if (hold_cfg)
                  state_q <= ST_ARMED;
               else if (double_q)
               begin
                  state_q <= ST_EDHI;
                  edit_q  <= addr_q;
               end
            ST_ARMED:
               if (single_q)
                  state_q <= ST_CFG;
               else if (idle_to | usb_cfg_done_i)
                  state_q <= ST_NORM;
            ST_CFG:
               if (hold_step)
                  state_q <= ST_NORM;
               else if (usb_cfg_done_i)
                  state_q <= ST_NORM;
            ST_EDHI:
               if (idle_to)
                  state_q <= ST_NORM;
               else if (hold_step)
                  state_q <= ST_EDLO;
               else if (short_rel)
                  edit_q[7:4] <= inc_dec(edit_q[7:4]);
            ST_EDLO:
               if (idle_to)
                  state_q <= ST_NORM;
               else if (hold_step)
                  state_q <= ST_NORM;
               else if (short_rel)
                  edit_q[3:0] <= inc_dec(edit_q[3:0]);
            default:
               state_q <= ST_NORM;
         endcase
      end
   end

   // saving from the panel wins over a bus write in the same cycle;
   // a bus value that is not two decimal digits is dropped
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
         addr_q <= `PBA_ADDR_RST;
      else if (state_q == ST_EDLO && hold_step && !idle_to)
         addr_q <= edit_q;
      else if (wr_pend_q && wr_addr_q == `PBA_REG_ADDR &&
               bcd_ok(hwdata_i[7:0]))
         addr_q <= hwdata_i[7:0];
   end

   // ***************************************************************
   // display drive
   // ***************************************************************
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         dig_hi_q    <= ADDR_RST[7:4];
         dig_lo_q    <= ADDR_RST[3:0];
         dig_hi_en_q <= 1'b1;
         dig_lo_en_q <= 1'b1;
      end
      else
      begin
         dig_hi_q    <= addr_q[7:4];
         dig_lo_q    <= addr_q[3:0];
         dig_hi_en_q <= 1'b1;
         dig_lo_en_q <= 1'b1;
         case (state_q)
            ST_ARMED:
            begin
               dig_hi_en_q <= blink_q;
               dig_lo_en_q <= blink_q;
            end
            ST_EDHI:
            begin
               dig_hi_q    <= edit_q[7:4];
               dig_lo_q    <= edit_q[3:0];
               dig_hi_en_q <= blink_q;
            end
            ST_EDLO:
            begin
               dig_hi_q    <= edit_q[7:4];
               dig_lo_q    <= edit_q[3:0];
               dig_lo_en_q <= blink_q;
            end
            default:
               dig_hi_en_q <= 1'b1;
         endcase
      end
   end

   // ***************************************************************
   // status indicators
   // ***************************************************************
   assign act_in = {tx_active_i, rx_active_i, fb_active_i};

   // one stretcher per activity source
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_act
         pba_act_led #(
            .CW       (CW),
            .HOLD_CYC (ACT_CYC)
         ) u_act (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .act_i     (act_in[gi]),
            .blink_i   (blink_q),
            .led_o     (act_led[gi])
         );
      end
   endgenerate

   // fault led is a steady copy of the fault level, no blinking
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
         fault_led_q <= 1'b0;
      else
         fault_led_q <= fb_fault_i;
   end

   // ***************************************************************
   // ahb-lite slave, zero wait states
   // ***************************************************************
   assign ahb_go = hsel_i & htrans_i[1] & hready_i;

   // read value chosen in the address phase; low byte decode only
   always @*
   begin
      rd_val = 32'h0000_0000;
      case (haddr_i[7:0])
         `PBA_REG_ADDR:
            rd_val[7:0] = addr_q;
         `PBA_REG_STATUS:
         begin
            rd_val[`PBA_ST_STATE_LSB +: 5] = state_q;
            rd_val[`PBA_ST_LEDS_LSB +: 4]  = {act_led[2:1], fault_led_q,
                                              act_led[0]};
            rd_val[`PBA_ST_EDIT_LSB +: 8]  = edit_q;
         end
         default:
            rd_val = 32'h0000_0000;
      endcase
   end

   // hsize is not checked: only whole-word transfers are expected
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q  <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= ahb_go & hwrite_i;
         if (ahb_go)
            wr_addr_q <= haddr_i[7:0];
         if (ahb_go & ~hwrite_i)
            hrdata_q <= rd_val;
         else
            hrdata_q <= 32'h0000_0000;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign hrdata_o                = hrdata_q;
   assign hreadyout_o             = 1'b1;
   assign hresp_o                 = 1'b0;
   assign digit_hi_o              = dig_hi_q;
   assign digit_lo_o              = dig_lo_q;
   assign digit_hi_en_o           = dig_hi_en_q;
   assign digit_lo_en_o           = dig_lo_en_q;
   assign slave_addr_o            = addr_q;
   assign cfg_mode_o              = state_q[2];
   assign fieldbus_activity_led_o = act_led[0];
   assign fieldbus_fault_led_o    = fault_led_q;
   assign rx_led_o                = act_led[1];
   assign tx_led_o                = act_led[2];

endmodule // pba_panel

`default_nettype wire

// ---- sim/pba_panel_props.sv ----
// checker for the panel block: bus answer, digit codes, leds, modes.
// assumes binding to pba_panel with its shortened activity stretch.
`timescale 1ns/10ps
`default_nettype none

module pba_panel_props #(
   parameter integer ACT_CYC = 2000000
) (
   input wire logic        clk_sys_i,
   input wire logic        rst_i,
   input wire logic        hsel_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        fb_active_i,
   input wire logic        fb_fault_i,
   input wire logic        usb_cfg_done_i,
   input wire logic [3:0]  digit_hi_o,
   input wire logic [3:0]  digit_lo_o,
   input wire logic        digit_hi_en_o,
   input wire logic        digit_lo_en_o,
   input wire logic [7:0]  slave_addr_o,
   input wire logic        cfg_mode_o,
   input wire logic        fieldbus_activity_led_o,
   input wire logic        fieldbus_fault_led_o
);
   // ***************************************************************
   // helper logic and assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   logic [31:0] quiet_q;

   // cycles since the last activity pulse, saturating to stay small
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i || fb_active_i)
         quiet_q <= 32'h0;
      else if (quiet_q < ACT_CYC + 8)
         quiet_q <= quiet_q + 32'h1;
   end

   AST_HREADY: assert property (hreadyout_o)
      else $error("bus slave inserted a wait state");
   AST_HRESP: assert property (!hresp_o)
      else $error("bus slave answered with an error");
   AST_HRDATA_IDLE: assert property (
      !$past(hsel_i && htrans_i[1] && !hwrite_i) |-> hrdata_o == 32'h0)
      else $error("read data outside a read data phase");
   AST_FAULT_LED: assert property (!$past(rst_i) |->
      fieldbus_fault_led_o == $past(fb_fault_i))
      else $error("fault led does not follow the fault input");
   AST_DIGITS_BCD: assert property (
      digit_hi_o <= 4'h9 && digit_lo_o <= 4'h9)
      else $error("display digit left the decimal range");
   AST_ADDR_BCD: assert property (
      slave_addr_o[7:4] <= 4'h9 && slave_addr_o[3:0] <= 4'h9)
      else $error("slave address is not two decimal digits");
   AST_ACT_IDLE: assert property (
      quiet_q >= ACT_CYC + 4 |-> !fieldbus_activity_led_o)
      else $error("activity led lit with no recent exchange");
   AST_CFG_STEADY: assert property (
      cfg_mode_o [*3] |-> digit_hi_en_o && digit_lo_en_o)
      else $error("display not steady in configuration mode");
   AST_USB_EXIT: assert property (
      cfg_mode_o && usb_cfg_done_i |-> ##[1:3] !cfg_mode_o)
      else $error("usb transfer end did not leave configuration");
endmodule // pba_panel_props

bind pba_panel pba_panel_props #(.ACT_CYC(ACT_CYC)) props_u (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .fb_active_i(fb_active_i), .fb_fault_i(fb_fault_i),
   .usb_cfg_done_i(usb_cfg_done_i), .digit_hi_o(digit_hi_o),
   .digit_lo_o(digit_lo_o), .digit_hi_en_o(digit_hi_en_o),
   .digit_lo_en_o(digit_lo_en_o), .slave_addr_o(slave_addr_o),
   .cfg_mode_o(cfg_mode_o),
   .fieldbus_activity_led_o(fieldbus_activity_led_o),
   .fieldbus_fault_led_o(fieldbus_fault_led_o));
`default_nettype wire

// ---- sim/pba_operator.sv ----
// operator model: presses the panel button, with contact bounce.
// assumes its task is called right after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module pba_operator (
   input  wire logic clk_sys_i,
   output var  logic button_n_o
);
   // ***************************************************************
   // button action
   // ***************************************************************
   initial button_n_o = 1'b1;

   // press n cycles, bouncing once at make, then leave it gap cycles;
   // the bounce is what a real contact does, so the filter must cope
   task automatic push(input int n, input int gap);
      button_n_o <= 1'b0;
      @(posedge clk_sys_i) button_n_o <= 1'b1;
      @(posedge clk_sys_i) button_n_o <= 1'b0;
      repeat (n) @(posedge clk_sys_i);
      button_n_o <= 1'b1;
      repeat (gap) @(posedge clk_sys_i);
   endtask
endmodule // pba_operator
`default_nettype wire

// ---- sim/tb_panel_button_address_ui.sv ----
// bench for the panel block: button sequences, leds, register bus.
// assumes shortened timing parameters and the operator model.
`timescale 1ns/10ps
`default_nettype none
`include "pba_map.vh"

module tb_panel_button_address_ui;
   // ***************************************************************
   // stimulus and checks
   // ***************************************************************
   localparam integer STEP = 100;
   localparam integer CFGH = 200;
   localparam integer IDLE = 400;
   logic        clk_sys_i = 1'b0;
   logic        rst_i     = 1'b1;
   logic        hsel_i    = 1'b0;
   logic [31:0] haddr_i   = 32'h0;
   logic [1:0]  htrans_i  = 2'h0;
   logic        hwrite_i  = 1'b0;
   logic [2:0]  hsize_i   = 3'h2;
   logic [31:0] hwdata_i  = 32'h0;
   logic [2:0]  act_v     = 3'h0;
   logic        fault     = 1'b0;
   logic        usb       = 1'b0;
   logic [31:0] rd;
   wire  [31:0] hrdata_o;
   wire         hrdy;
   wire         btn_n;
   wire  [3:0]  dh;
   wire  [3:0]  dl;
   wire         dhe;
   wire         dle;
   wire  [7:0]  sa;
   wire         cfg;
   wire         fled;
   wire  [2:0]  leds;
   int          fail_count = 0;
   int          comparisons = 0;

   always #25 clk_sys_i = ~clk_sys_i;

   pba_operator op_u (.clk_sys_i(clk_sys_i), .button_n_o(btn_n));

   pba_panel #(.HOLD_CFG(CFGH), .HOLD_STEP(STEP), .IDLE_CYC(IDLE),
      .DEB_CYC(4), .GAP_CYC(30), .BLINK_CYC(8), .ACT_CYC(20)) dut_u (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hrdy),
      .hrdata_o(hrdata_o), .hreadyout_o(hrdy), .hresp_o(),
      .button_n_i(btn_n), .fb_active_i(act_v[0]), .fb_fault_i(fault),
      .rx_active_i(act_v[1]), .tx_active_i(act_v[2]),
      .usb_cfg_done_i(usb), .digit_hi_o(dh), .digit_lo_o(dl),
      .digit_hi_en_o(dhe), .digit_lo_en_o(dle), .slave_addr_o(sa),
      .cfg_mode_o(cfg), .fieldbus_activity_led_o(leds[0]),
      .fieldbus_fault_led_o(fled), .rx_led_o(leds[1]),
      .tx_led_o(leds[2]));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one single transfer, then an idle cycle so reads see prior writes
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel_i <= 1'b1;
      htrans_i <= 2'b10;
      haddr_i <= a;
      hwrite_i <= w;
      do @(posedge clk_sys_i); while (hrdy !== 1'b1);
      htrans_i <= 2'b00;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      do @(posedge clk_sys_i); while (hrdy !== 1'b1);
      rd = hrdata_o;
      @(posedge clk_sys_i);
   endtask

   task automatic st(input logic [4:0] e);
      bus(1'b0, `PBA_REG_STATUS, 32'h0);
      chk("state", {27'h0, e}, {27'h0, rd[4:0]});
   endtask

   // sample both digit enables long enough to span a blink period
   task automatic blink(input logic eh, el);
      int nh;
      int nl;
      nh = 0;
      nl = 0;
      repeat (24)
      begin
         @(posedge clk_sys_i);
         nh += int'(!dhe);
         nl += int'(!dle);
      end
      chk("hi_blink", {31'h0, eh}, {31'h0, nh > 0});
      chk("lo_blink", {31'h0, el}, {31'h0, nl > 0});
   endtask

   task automatic led(input int k);
      logic seen;
      seen = 1'b0;
      act_v[k] <= 1'b1;
      @(posedge clk_sys_i) act_v[k] <= 1'b0;
      repeat (30) @(posedge clk_sys_i) seen |= leds[k];
      chk("led_on", 32'h1, {31'h0, seen});
      repeat (40) @(posedge clk_sys_i);
      chk("led_off", 32'h0, {31'h0, leds[k]});
   endtask

   // watchdog: the sequence needs well under a quarter of this span
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      fail_count++;
      final_report;
   end

   initial
   begin
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      bus(1'b0, `PBA_REG_ADDR, 32'h0);
      chk("addr", {24'h0, `PBA_ADDR_RST}, rd);
      chk("display", 32'h0b, {22'h0, dh, dl, dhe, dle});
      st(5'h01);
      op_u.push(10, 10);
      op_u.push(10, 50);
      st(5'h08);
      blink(1'b1, 1'b0);
      op_u.push(10, 50);
      st(5'h08);
      chk("edit", 32'h12, {24'h0, rd[23:16]});
      op_u.push(STEP + 20, 50);
      st(5'h10);
      blink(1'b0, 1'b1);
      repeat (8) op_u.push(10, 50);
      st(5'h10);
      chk("edit", 32'h10, {24'h0, rd[23:16]});
      op_u.push(STEP + 20, 50);
      st(5'h01);
      chk("slave", 32'h10, {24'h0, sa});
      op_u.push(10, 10);
      op_u.push(10, 50);
      op_u.push(10, IDLE + 40);
      st(5'h01);
      chk("slave", 32'h10, {24'h0, sa});
      op_u.push(CFGH + 20, 0);
      st(5'h02);
      blink(1'b1, 1'b1);
      repeat (20) @(posedge clk_sys_i);
      op_u.push(10, 50);
      st(5'h04);
      chk("cfg", 32'h1, {31'h0, cfg});
      op_u.push(10, 50);
      st(5'h04);
      op_u.push(STEP + 20, 50);
      st(5'h01);
      op_u.push(CFGH + 20, 50);
      op_u.push(10, 50);
      usb <= 1'b1;
      @(posedge clk_sys_i) usb <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      st(5'h01);
      for (int k = 0; k < 3; k++) led(k);
      fault <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk("fault_led", 32'h1, {31'h0, fled});
      fault <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk("fault_led", 32'h0, {31'h0, fled});
      bus(1'b1, `PBA_REG_ADDR, 32'h47);
      bus(1'b0, `PBA_REG_ADDR, 32'h0);
      chk("addr", 32'h47, rd);
      chk("slave", 32'h47, {24'h0, sa});
      bus(1'b1, `PBA_REG_ADDR, 32'h4a);
      bus(1'b0, `PBA_REG_ADDR, 32'h0);
      chk("addr", 32'h47, rd);
      bus(1'b1, `PBA_REG_STATUS, 32'hff);
      st(5'h01);
      bus(1'b0, 32'h08, 32'h0);
      chk("unmapped", 32'h0, rd);
      final_report;
   end
endmodule // tb_panel_button_address_ui
`default_nettype wire
